// ---- hw/page_walk_protection_check.sv ----
// Three-level page-table walker with per-mode access check.
// Assumes a single pclk domain, an APB master for the base frame and
// status, and a memory port that answers each entry read with mem_ack.
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "walk_regs.svh"

module page_walk_protection_check #(
  parameter int PB = 13 // Byte-within-page bits
) (
  input wire logic pclk, // Processor clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic req_valid, // Translation request
  output logic req_ready, // Walker idle
  input wire walk_pkg::walk_req_s req, // Address, access, mode
  output logic rsp_valid, // Answer pulse
  output walk_pkg::walk_rsp_s rsp, // Physical address and fault
  output logic mem_req_valid, // Entry read request
  output logic [63:0] mem_addr, // Entry physical address
  input wire logic mem_ack, // Entry returned
  input wire logic [63:0] mem_rdata // Entry contents
);

  localparam int IB = PB - 3;
  localparam int VA_SIZE = PB + 3 * IB;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  walk_pkg::walk_state_e state_ff, nxt_state;
  walk_pkg::walk_req_s req_ff;
  walk_pkg::walk_rsp_s rsp_ff, nxt_rsp;
  logic [63:0] lvl_addr_ff, nxt_lvl_addr;
  logic [31:0] tbf_ff;
  logic [31:0] base_ff;
  logic [31:0] prdata_ff;
  walk_pkg::fault_e last_fault_ff;

  // ---------------------------------------------------------------
  // Decode of request and returned entry
  // ---------------------------------------------------------------
  wire req_take = req_valid && req_ready;
  wire [63-VA_SIZE+1:0] va_hi = req.va[63:VA_SIZE-1];
  wire sext_ok = (&va_hi) || !(|va_hi);
  wire [IB-1:0] idx1 = req_ff.va[PB+3*IB-1 -: IB];
  wire [IB-1:0] idx2 = req_ff.va[PB+2*IB-1 -: IB];
  wire [IB-1:0] idx3 = req_ff.va[PB+IB-1 -: IB];
  wire [31:0] pte_frame = mem_rdata[`WALK_FRAME_HI:`WALK_FRAME_LO];
  wire pte_v = mem_rdata[`WALK_V_BIT];
  wire pte_kernel_read = mem_rdata[`WALK_RE_LO];
  wire [3:0] pte_we = mem_rdata[`WALK_WE_LO+3:`WALK_WE_LO];
  wire [3:0] pte_re = mem_rdata[`WALK_RE_LO+3:`WALK_RE_LO];
  wire is_write = req_ff.access == walk_pkg::ACC_WRITE;
  wire is_fetch = req_ff.access == walk_pkg::ACC_FETCH;
  wire is_load = req_ff.access == walk_pkg::ACC_READ;
  // Mode number indexes the enable nibble directly, kernel at bit 0
  wire mode_we = pte_we[req_ff.current_mode_field];
  wire mode_re = pte_re[req_ff.current_mode_field];
  wire prot_fail = is_write ? !mode_we : !mode_re;
  // A probed queue request tolerates a since-cleared valid bit
  wire l3_valid = pte_v || req_ff.probed;
  wire [63:0] l1_addr = 64'({tbf_ff, req.va[PB+3*IB-1 -: IB], 3'h0});
  wire [63:0] l2_addr = 64'({pte_frame, idx2, 3'h0});
  wire [63:0] l3_addr = 64'({pte_frame, idx3, 3'h0});
  wire [63:0] final_pa = 64'({pte_frame, req_ff.va[PB-1:0]});
  wire upper_bad = !pte_v;
  wire walk_fault_pick = pte_kernel_read; // Kernel read set means not-valid, else violation

  // ---------------------------------------------------------------
  // Handshake outputs
  // ---------------------------------------------------------------
  assign req_ready = state_ff == walk_pkg::ST_IDLE;
  assign rsp_valid = state_ff == walk_pkg::ST_DONE;
  assign rsp = rsp_ff;
  // Read-only port: no write strobe exists toward the page tables
  assign mem_req_valid = (state_ff == walk_pkg::ST_L1) || (state_ff == walk_pkg::ST_L2)
                         || (state_ff == walk_pkg::ST_L3);
  assign mem_addr = lvl_addr_ff;

  // ---------------------------------------------------------------
  // Walk sequencing
  // ---------------------------------------------------------------
  // Third-level precedence: violation, not-valid, then fault bits
  always_comb
  begin
    nxt_state = state_ff;
    nxt_rsp = rsp_ff;
    nxt_lvl_addr = lvl_addr_ff;
    unique case (state_ff)
      walk_pkg::ST_IDLE:
      begin
        if (req_take)
        begin
          nxt_rsp = '{pa: 64'h0, fault: walk_pkg::FAULT_NONE};
          if (req.access == walk_pkg::ACC_ADDR)
          begin
            nxt_state = walk_pkg::ST_DONE;
          end
          else if (!sext_ok)
          begin
            nxt_rsp.fault = walk_pkg::FAULT_ACV;
            nxt_state = walk_pkg::ST_DONE;
          end
          else
          begin
            nxt_lvl_addr = l1_addr;
            nxt_state = walk_pkg::ST_L1;
          end
        end
      end
      walk_pkg::ST_L1, walk_pkg::ST_L2:
      begin
        // Wait here; the next address needs the returned frame
        if (mem_ack)
        begin
          if (upper_bad)
          begin
            nxt_rsp.fault = walk_fault_pick ? walk_pkg::FAULT_TNV
                                            : walk_pkg::FAULT_ACV;
            nxt_state = walk_pkg::ST_DONE;
          end
          else
          begin
            // Protection bits of a valid upper entry play no part
            nxt_lvl_addr = (state_ff == walk_pkg::ST_L1) ? l2_addr : l3_addr;
            nxt_state = (state_ff == walk_pkg::ST_L1) ? walk_pkg::ST_L2
                                                      : walk_pkg::ST_L3;
          end
        end
      end
      walk_pkg::ST_L3:
      begin
        if (mem_ack)
        begin
          nxt_state = walk_pkg::ST_DONE;
          if (prot_fail)
            nxt_rsp.fault = walk_pkg::FAULT_ACV;
          else if (!l3_valid)
            nxt_rsp.fault = walk_pkg::FAULT_TNV;
          else if (is_write && mem_rdata[`WALK_STORE_FAULT_BIT])
            nxt_rsp.fault = walk_pkg::FAULT_FOW;
          else if (is_load && mem_rdata[`WALK_FOR_BIT])
            nxt_rsp.fault = walk_pkg::FAULT_FOR;
          else if (is_fetch && mem_rdata[`WALK_EXEC_FAULT_BIT])
            nxt_rsp.fault = walk_pkg::FAULT_FOE;
          else
            nxt_rsp.pa = final_pa;
        end
      end
      walk_pkg::ST_DONE:
      begin
        nxt_state = walk_pkg::ST_IDLE;
      end
      default:
      begin
        nxt_state = walk_pkg::ST_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= walk_pkg::ST_IDLE;
      rsp_ff <= '0;
      lvl_addr_ff <= 64'h0;
      req_ff <= '0;
      base_ff <= 32'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      rsp_ff <= nxt_rsp;
      lvl_addr_ff <= nxt_lvl_addr;
      if (req_take)
      begin
        req_ff <= req;
        base_ff <= tbf_ff;
      end
    end
  end

  // Last fault is kept for software to inspect after the answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      last_fault_ff <= walk_pkg::FAULT_NONE;
    else if (state_ff == walk_pkg::ST_DONE)
      last_fault_ff <= rsp_ff.fault;
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pwrite;
  wire hit_tbf = paddr == `WALK_TBF_OFF;
  wire hit_stat = paddr == `WALK_STAT_OFF;
  wire [31:0] stat_word = 32'({!req_ready, last_fault_ff});
  wire [31:0] rd_mux = hit_tbf ? tbf_ff : (hit_stat ? stat_word : 32'h0);

  assign pready = 1'b1;
  assign pslverr = psel && penable && !(hit_tbf || hit_stat);
  assign prdata = prdata_ff;

  // Read data is captured in setup so it comes from a flop at access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= 32'h0;
    else if (apb_setup)
      prdata_ff <= rd_mux;
  end

  // The base frame is sampled per request, so a write mid-walk is safe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tbf_ff <= `WALK_TBF_RST;
    else if (apb_wr && hit_tbf)
      tbf_ff <= pwdata;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_addr_held: assert property (
    mem_req_valid && !mem_ack |=> mem_req_valid && $stable(mem_addr))
    else $error("entry read changed before acknowledge");

  a_l1_address: assert property (
    state_ff == walk_pkg::ST_L1 |-> mem_addr == 64'({base_ff, idx1, 3'h0}))
    else $error("first-level entry address wrong");

  a_l2_address: assert property (
    state_ff == walk_pkg::ST_L1 && mem_ack && pte_v
    |=> mem_addr == 64'({$past(mem_rdata[63:32]), idx2, 3'h0}))
    else $error("second-level entry address wrong");

  a_addr_operand: assert property (
    req_take && req.access == walk_pkg::ACC_ADDR
    |=> rsp_valid && rsp.fault == walk_pkg::FAULT_NONE ##0 !mem_req_valid [*2])
    else $error("address operand touched memory or faulted");

  a_sext_fault: assert property (
    req_take && req.access != walk_pkg::ACC_ADDR && !sext_ok
    |=> rsp_valid && rsp.fault == walk_pkg::FAULT_ACV)
    else $error("bad sign extension not reported");

  a_upper_invalid: assert property (
    (state_ff == walk_pkg::ST_L1 || state_ff == walk_pkg::ST_L2) && mem_ack && !pte_v
    |=> rsp_valid && rsp.fault == ($past(pte_kernel_read) ? walk_pkg::FAULT_TNV
                                                  : walk_pkg::FAULT_ACV))
    else $error("invalid upper entry fault wrong");

  a_prot_first: assert property (
    state_ff == walk_pkg::ST_L3 && mem_ack && prot_fail
    |=> rsp_valid && rsp.fault == walk_pkg::FAULT_ACV)
    else $error("protection failure not ranked first");

  a_store_fault: assert property (
    state_ff == walk_pkg::ST_L3 && mem_ack && !prot_fail && l3_valid && is_write
    && mem_rdata[`WALK_STORE_FAULT_BIT] |=> rsp.fault == walk_pkg::FAULT_FOW)
    else $error("fault on store missed");

  a_final_pa: assert property (
    state_ff == walk_pkg::ST_L3 && mem_ack && nxt_rsp.fault == walk_pkg::FAULT_NONE
    |=> rsp.pa == 64'({$past(mem_rdata[63:32]), req_ff.va[PB-1:0]}))
    else $error("physical address wrong");

endmodule : page_walk_protection_check

// ---- hw/walk_regs.svh ----
// Register offsets, entry field positions and reset values of the walker.
// Assumes inclusion by bare name from the walker module and the test bench.
`ifndef WALK_REGS_SVH
`define WALK_REGS_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses on APB)
// ---------------------------------------------------------------
`define WALK_TBF_OFF 12'h000
`define WALK_STAT_OFF 12'h004

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define WALK_TBF_RST 32'h0000_0000

// ---------------------------------------------------------------
// Page-table entry fields
// ---------------------------------------------------------------
`define WALK_FRAME_HI 63
`define WALK_FRAME_LO 32
`define WALK_WE_LO 12
`define WALK_RE_LO 8
`define WALK_EXEC_FAULT_BIT 3
`define WALK_STORE_FAULT_BIT 2
`define WALK_FOR_BIT 1
`define WALK_V_BIT 0

// ---------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------
`define WALK_STAT_BUSY_BIT 3
`define WALK_STAT_FAULT_LO 0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define WALK_CLK_PERIOD_NS 10

`endif

// ---- hw/walk_pkg.sv ----
// Types shared by the page-table walker and its surroundings.
// Holds its numeric constants inline, without walk_regs.svh.
package walk_pkg;

  // ---------------------------------------------------------------
  // Modes, access kinds and fault codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_KERNEL = 2'h0,
    MODE_EXEC = 2'h1,
    MODE_SUPER = 2'h2,
    MODE_USER = 2'h3
  } mode_e;

  typedef enum logic [1:0] {
    ACC_READ = 2'h0,
    ACC_WRITE = 2'h1,
    ACC_FETCH = 2'h2,
    ACC_ADDR = 2'h3
  } acc_e;

  typedef enum logic [2:0] {
    FAULT_NONE = 3'h0,
    FAULT_ACV = 3'h1,
    FAULT_TNV = 3'h2,
    FAULT_FOR = 3'h3,
    FAULT_FOW = 3'h4,
    FAULT_FOE = 3'h5
  } fault_e;

  // ---------------------------------------------------------------
  // Walker states
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_L1 = 5'h02,
    ST_L2 = 5'h04,
    ST_L3 = 5'h08,
    ST_DONE = 5'h10
  } walk_state_e;

  // ---------------------------------------------------------------
  // Request and answer carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [63:0] va;
    acc_e access;
    mode_e current_mode_field;
    logic probed;
  } walk_req_s;

  typedef struct packed {
    logic [63:0] pa;
    fault_e fault;
  } walk_rsp_s;

endpackage : walk_pkg

// ---- verification/mem_model.sv ----
// Memory model that holds page-table entries and answers walker reads.
// Assumes the bench fills tbl and sets lat through the hierarchy.
`timescale 1ns/1ps

module mem_model (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic mem_req_valid, // Entry read request
  input wire logic [63:0] mem_addr, // Entry address
  output logic mem_ack, // Entry returned
  output logic [63:0] mem_rdata // Entry contents
);
  logic [63:0] tbl [logic [63:0]];
  logic [63:0] addrs [$];
  int lat = 0;
  int cnt;

  // -------------------------------------------------------------
  // Read responder
  // -------------------------------------------------------------
  // One whole entry per ack; data toggles off the ack so stale values never match
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_ack <= 1'b0;
      mem_rdata <= 64'h0;
      cnt <= 0;
    end
    else if (mem_req_valid && !mem_ack && cnt >= lat)
    begin
      mem_ack <= 1'b1;
      mem_rdata <= tbl.exists(mem_addr) ? tbl[mem_addr] : 64'h0;
      addrs.push_back(mem_addr);
      cnt <= 0;
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt <= mem_req_valid ? cnt + 1 : 0;
    end
  end
endmodule : mem_model

// ---- verification/page_walk_protection_check_test.sv ----
// Self-checking bench for the page-table walker and access checker.
// Assumes the memory model answers entry reads; APB reaches the registers.
`timescale 1ns/1ps
`include "walk_regs.svh"

module page_walk_protection_check_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic req_valid, req_ready, rsp_valid, mem_req_valid, mem_ack, er;
  logic [63:0] mem_addr, mem_rdata, va;
  walk_pkg::walk_req_s req;
  walk_pkg::walk_rsp_s rsp, got;
  int bad_count, n_checks;
  localparam logic [31:0] TBASE = 32'h0000_0010;
  localparam logic [15:0] FULL = 16'hff01;

  page_walk_protection_check #(.PB(13)) page_walk_protection_check_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
    .rsp(rsp), .mem_req_valid(mem_req_valid), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  mem_model mem_model_inst (.pclk(pclk), .presetn(presetn), .mem_req_valid(mem_req_valid),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // -------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Hold the request until pready is seen high with penable
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [63:0] ea(input logic [31:0] f, input logic [9:0] i);
    return 64'({f, 13'h0}) + 64'({i, 3'h0});
  endfunction : ea

  task automatic map(input logic [15:0] l1, input logic [15:0] l2, input logic [15:0] l3);
    mem_model_inst.tbl.delete();
    mem_model_inst.tbl[ea(TBASE, va[42:33])] = {32'h20, 16'h0, l1};
    mem_model_inst.tbl[ea(32'h20, va[32:23])] = {32'h30, 16'h0, l2};
    mem_model_inst.tbl[ea(32'h30, va[22:13])] = {32'habc, 16'h0, l3};
  endtask : map

  // Requests start only once the previous answer has passed
  task automatic run(input walk_pkg::acc_e ac, input int md, input logic pr,
    input logic [15:0] l1, input logic [15:0] l2, input logic [15:0] l3,
    input walk_pkg::fault_e f, input int nr);
    int n;
    n = 0;
    map(l1, l2, l3);
    mem_model_inst.addrs.delete();
    @(posedge pclk);
    req <= '{va: va, access: ac, current_mode_field: walk_pkg::mode_e'(md[1:0]), probed: pr};
    req_valid <= 1'b1;
    @(posedge pclk);
    req_valid <= 1'b0;
    // A one-cycle answer stands right after the take edge, so look there first
    #1;
    while (rsp_valid !== 1'b1 && n < 100)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    got = rsp;
    chk(64'(n < 100), 64'h1);
    chk(64'(got.fault), 64'(f));
    chk(64'(mem_model_inst.addrs.size()), 64'(nr));
  endtask : run

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, `WALK_TBF_OFF, 32'h0);
    chk(64'(rd), 64'(`WALK_TBF_RST));
    apb(1'b1, `WALK_TBF_OFF, TBASE);
    apb(1'b0, `WALK_TBF_OFF, 32'h0);
    chk(64'(rd), 64'(TBASE));
    apb(1'b1, `WALK_STAT_OFF, 32'hffff_ffff);
    apb(1'b0, `WALK_STAT_OFF, 32'h0);
    chk(64'(rd), 64'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk(64'(er), 64'h1);
    $display("test regs done");
  endtask : t_regs

  task automatic t_walk;
    for (int s = 0; s < 2; s++)
    begin
      mem_model_inst.lat = 3 * s;
      run(walk_pkg::ACC_READ, 0, 1'b0, 16'h0001, 16'h0001, FULL, walk_pkg::FAULT_NONE, 3);
      chk(got.pa, {19'h0, 32'habc, va[12:0]});
      chk(mem_model_inst.addrs[0], ea(TBASE, va[42:33]));
      chk(mem_model_inst.addrs[1], ea(32'h20, va[32:23]));
      chk(mem_model_inst.addrs[2], ea(32'h30, va[22:13]));
    end
    mem_model_inst.lat = 0;
    $display("test walk done");
  endtask : t_walk

  // Each mode loses only its own enable; its neighbour still passes a read
  task automatic t_modes;
    for (int m = 0; m < 4; m++)
    begin
      run(walk_pkg::ACC_READ, m, 1'b0, 16'h1, 16'h1, FULL & ~(16'h100 << m), walk_pkg::FAULT_ACV, 3);
      run(walk_pkg::ACC_READ, (m + 1) % 4, 1'b0, 16'h1, 16'h1, FULL & ~(16'h100 << m), walk_pkg::FAULT_NONE, 3);
      run(walk_pkg::ACC_WRITE, m, 1'b0, 16'h1, 16'h1, FULL & ~(16'h1000 << m), walk_pkg::FAULT_ACV, 3);
      run(walk_pkg::ACC_FETCH, m, 1'b0, 16'h1, 16'h1, FULL & ~(16'h100 << m), walk_pkg::FAULT_ACV, 3);
    end
    apb(1'b0, `WALK_STAT_OFF, 32'h0);
    chk(64'(rd), 64'(walk_pkg::FAULT_ACV));
    $display("test modes done");
  endtask : t_modes

  task automatic t_levels;
    run(walk_pkg::ACC_READ, 0, 1'b0, 16'h0000, 16'h1, FULL, walk_pkg::FAULT_ACV, 1);
    run(walk_pkg::ACC_READ, 0, 1'b0, 16'h0100, 16'h1, FULL, walk_pkg::FAULT_TNV, 1);
    run(walk_pkg::ACC_WRITE, 3, 1'b0, 16'h1, 16'h0000, FULL, walk_pkg::FAULT_ACV, 2);
    run(walk_pkg::ACC_WRITE, 3, 1'b0, 16'h1, 16'h0100, FULL, walk_pkg::FAULT_TNV, 2);
    run(walk_pkg::ACC_READ, 0, 1'b0, 16'h1, 16'h1, 16'h0000, walk_pkg::FAULT_ACV, 3);
    run(walk_pkg::ACC_READ, 0, 1'b0, 16'h1, 16'h1, FULL & ~16'h1, walk_pkg::FAULT_TNV, 3);
    run(walk_pkg::ACC_READ, 0, 1'b1, 16'h1, 16'h1, FULL & ~16'h1, walk_pkg::FAULT_NONE, 3);
    run(walk_pkg::ACC_READ, 0, 1'b1, 16'h1, 16'h1, 16'h0000, walk_pkg::FAULT_ACV, 3);
    $display("test levels done");
  endtask : t_levels

  // The execute-only page sets read enables with both read and write faults
  task automatic t_faults;
    run(walk_pkg::ACC_WRITE, 1, 1'b0, 16'h1, 16'h1, FULL | 16'h6, walk_pkg::FAULT_FOW, 3);
    run(walk_pkg::ACC_READ, 2, 1'b0, 16'h1, 16'h1, FULL | 16'h2, walk_pkg::FAULT_FOR, 3);
    run(walk_pkg::ACC_FETCH, 3, 1'b0, 16'h1, 16'h1, FULL | 16'h8, walk_pkg::FAULT_FOE, 3);
    run(walk_pkg::ACC_READ, 3, 1'b0, 16'h1, 16'h1, FULL | 16'h8, walk_pkg::FAULT_NONE, 3);
    run(walk_pkg::ACC_FETCH, 0, 1'b0, 16'h1, 16'h1, 16'h0f07, walk_pkg::FAULT_NONE, 3);
    run(walk_pkg::ACC_READ, 0, 1'b0, 16'h1, 16'h1, 16'h0f07, walk_pkg::FAULT_FOR, 3);
    run(walk_pkg::ACC_WRITE, 0, 1'b0, 16'h1, 16'h1, 16'h0f07, walk_pkg::FAULT_ACV, 3);
    $display("test faults done");
  endtask : t_faults

  task automatic t_special;
    run(walk_pkg::ACC_ADDR, 3, 1'b0, 16'h0, 16'h0, 16'h0, walk_pkg::FAULT_NONE, 0);
    chk(got.pa, 64'h0);
    va = 64'h0000_0400_0000_0000;
    run(walk_pkg::ACC_READ, 0, 1'b0, 16'h1, 16'h1, FULL, walk_pkg::FAULT_ACV, 0);
    va = 64'hffff_fc00_0000_0000;
    run(walk_pkg::ACC_READ, 0, 1'b0, 16'h1, 16'h1, FULL, walk_pkg::FAULT_NONE, 3);
    $display("test special done");
  endtask : t_special

  // -------------------------------------------------------------
  // Main sequence and watchdog
  // -------------------------------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, req_valid} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    req = '0;
    va = 64'h0000_0123_4567_8a5c;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_walk();
    t_modes();
    t_levels();
    t_faults();
    t_special();
    close_out();
  end

  // About 36 walks of a few cycles each; this span leaves wide margin
  initial
  begin
    #200000;
    bad_count++;
    close_out();
  end
endmodule : page_walk_protection_check_test
